// ==== cptc_pkg.sv ====
// package: register offsets, field positions, masks and encodings for the power tune and channel 1 setup bank
package cptc_pkg;
  // register addresses on the control interface
  localparam logic [7:0] ADDR_ADC_POWER_TUNING  = 8'h4E;
  localparam logic [7:0] ADDR_DAC_POWER_TUNING  = 8'h4F;
  localparam logic [7:0] ADDR_ADC_FIRST_CHANNEL = 8'h50;
  localparam int         NUM_REGS               = 3;
  localparam logic [7:0] REG_RESET              = 8'h00;
  localparam logic [7:0] READ_UNMAPPED          = 8'h00;
  // writable bit masks; all other bits are reserved and read zero
  localparam logic [7:0] MASK_ADC_POWER_TUNING  = 8'hE4;
  localparam logic [7:0] MASK_DAC_POWER_TUNING  = 8'hA6;
  localparam logic [7:0] MASK_ADC_FIRST_CHANNEL = 8'hC3;
  // adc power tuning fields
  localparam int ADC_HALF_RATE_BIT  = 7;
  localparam int ADC_COMB_ORDER_BIT = 6;
  localparam int ADC_FIR_SKIP_BIT   = 5;
  localparam int ADC_LOWPWR_BIT     = 2;
  // dac power tuning fields
  localparam int DAC_HALF_RATE_BIT  = 7;
  localparam int DAC_SEG_SKIP_BIT   = 5;
  localparam int DAC_LOWPWR_BIT     = 2;
  localparam int DAC_REFERENCE_CURRENT_HALF_BIT  = 1;
  // channel 1 setup fields
  localparam int CH1_INSRC_HI_BIT   = 7;
  localparam int CH1_INSRC_LO_BIT   = 6;
  localparam int CH1_RANGE_BIT      = 1;
  localparam int CH1_BW_BIT         = 0;
  // encodings
  localparam logic [1:0] INSRC_DIFFERENTIAL = 2'h0;
  localparam logic [1:0] INSRC_SINGLE_ENDED = 2'h1;
  localparam logic       CIC_ORDER_FIFTH    = 1'h0;
  localparam logic       CIC_ORDER_FOURTH   = 1'h1;
endpackage

// ==== cptc_regmem.sv ====
// module: small register array with masked writes and registered read data
`timescale 1ns/1ps
`default_nettype none
module cptc_regmem (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       wr_en,
  input  wire logic [1:0] wr_idx,
  input  wire logic [7:0] wr_data,
  input  wire logic [1:0] rd_idx,
  output logic      [7:0] rd_data,
  output logic      [7:0] reg_adc,
  output logic      [7:0] reg_dac,
  output logic      [7:0] reg_ch1
);
  typedef struct packed {
    logic [cptc_pkg::NUM_REGS-1:0][7:0] regs;
    logic [7:0]                         rd;
  } cptc_mem_state_t;

  cptc_mem_state_t state_q;
  cptc_mem_state_t state_d;
  logic [cptc_pkg::NUM_REGS-1:0][7:0] wmask;

  assign wmask[0] = cptc_pkg::MASK_ADC_POWER_TUNING;
  assign wmask[1] = cptc_pkg::MASK_DAC_POWER_TUNING;
  assign wmask[2] = cptc_pkg::MASK_ADC_FIRST_CHANNEL;

  // reserved bits are masked on write so they can never read back as one
  always_comb begin
    state_d = state_q;
    for (int i = 0; i < cptc_pkg::NUM_REGS; i++) begin
      if (wr_en && (wr_idx == 2'(i))) begin
        state_d.regs[i] = wr_data & wmask[i];
      end
    end
    if (rd_idx < 2'(cptc_pkg::NUM_REGS)) begin
      state_d.rd = state_q.regs[rd_idx];
    end else begin
      state_d.rd = cptc_pkg::READ_UNMAPPED;
    end
  end

  // every register starts at zero
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q.regs <= {cptc_pkg::NUM_REGS{cptc_pkg::REG_RESET}};
      state_q.rd   <= cptc_pkg::REG_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign rd_data = state_q.rd;
  assign reg_adc = state_q.regs[0];
  assign reg_dac = state_q.regs[1];
  assign reg_ch1 = state_q.regs[2];
endmodule
`default_nettype wire

// ==== cptc_bank.sv ====
// module: codec power tune and adc channel 1 configuration register bank
//
// Functional notes
// - adc_modulator_half_rate runs the adc modulator at 3MHz when 0 and 1.5MHz when 1.
// - adc_comb_order_select picks a fifth-order comb stage when 0 and fourth-order when 1.
// - adc_decim_filter_skip set routes adc samples around the fir decimation stage.
// - adc_lowpower_filter_en set selects the low-power adc filter variant.
// - dac_modulator_half_rate runs the dac modulator at 3MHz when 0 and 1.5MHz when 1.
// - dac_interp_segmenter_skip set skips both the dac fir interpolator and the segmenter.
// - dac_lowpower_filter_en set selects the low-power dac filter variant.
// - dac_ref_current_half selects reference current Vref/R when 0 and Vref/2R when 1.
// - first_channel_input_type code 0 is differential, 1 single-ended; codes 2 and 3 are not to be used.
// - first_channel_range_select gives 10 Vrms full scale when 0 and 5 Vrms when 1 at a 2.75 V reference.
// - first_channel_bandwidth_select gives 24 kHz audio bandwidth when 0 and 96 kHz wide when 1.
// - reserved bits read back zero and software writes only zero to them.
// - after reset all three registers hold 0x00.
`timescale 1ns/1ps
`default_nettype none
module cptc_bank (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       reg_wr_en,
  input  wire logic       reg_rd_en,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  output logic            adc_modulator_half_rate,
  output logic            adc_comb_order_select,
  output logic            adc_decim_filter_skip,
  output logic            adc_lowpower_filter_en,
  output logic            dac_modulator_half_rate,
  output logic            dac_interp_segmenter_skip,
  output logic            dac_lowpower_filter_en,
  output logic            dac_ref_current_half,
  output logic      [1:0] first_channel_input_type,
  output logic            first_channel_range_select,
  output logic            first_channel_bandwidth_select,
  output logic            first_channel_input_invalid
);
  typedef struct packed {
    logic rvalid;
  } cptc_state_t;

  cptc_state_t state_q;
  cptc_state_t state_d;
  logic [1:0]  wr_idx;
  logic [1:0]  rd_idx;
  logic        wr_hit;
  logic [7:0]  reg_adc;
  logic [7:0]  reg_dac;
  logic [7:0]  reg_ch1;

  // address decode; an unmapped index reads zero and drops writes
  function automatic logic [1:0] cptc_decode(input logic [7:0] addr);
    logic [1:0] idx;
    idx = 2'h3;
    case (addr)
      cptc_pkg::ADDR_ADC_POWER_TUNING:  idx = 2'h0;
      cptc_pkg::ADDR_DAC_POWER_TUNING:  idx = 2'h1;
      cptc_pkg::ADDR_ADC_FIRST_CHANNEL: idx = 2'h2;
      default:                          idx = 2'h3;
    endcase
    return idx;
  endfunction

  assign wr_idx = cptc_decode(reg_addr);
  assign rd_idx = cptc_decode(reg_addr);
  assign wr_hit = reg_wr_en && (wr_idx != 2'h3);

  cptc_regmem u_mem (
    .core_clk (core_clk),
    .reset    (reset),
    .wr_en    (wr_hit),
    .wr_idx   (wr_idx),
    .wr_data  (reg_wdata),
    .rd_idx   (rd_idx),
    .rd_data  (reg_rdata),
    .reg_adc  (reg_adc),
    .reg_dac  (reg_dac),
    .reg_ch1  (reg_ch1)
  );

  // read data lands one cycle after the read strobe
  always_comb begin
    state_d        = state_q;
    state_d.rvalid = reg_rd_en;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q.rvalid <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  assign reg_rvalid = state_q.rvalid;

  // adc datapath controls straight from register flops
  assign adc_modulator_half_rate = reg_adc[cptc_pkg::ADC_HALF_RATE_BIT];
  assign adc_comb_order_select   = reg_adc[cptc_pkg::ADC_COMB_ORDER_BIT];
  assign adc_decim_filter_skip   = reg_adc[cptc_pkg::ADC_FIR_SKIP_BIT];
  assign adc_lowpower_filter_en  = reg_adc[cptc_pkg::ADC_LOWPWR_BIT];

  // dac datapath controls; one skip bit drops both fir and segmenter
  assign dac_modulator_half_rate   = reg_dac[cptc_pkg::DAC_HALF_RATE_BIT];
  assign dac_interp_segmenter_skip = reg_dac[cptc_pkg::DAC_SEG_SKIP_BIT];
  assign dac_lowpower_filter_en    = reg_dac[cptc_pkg::DAC_LOWPWR_BIT];
  assign dac_ref_current_half      = reg_dac[cptc_pkg::DAC_REFERENCE_CURRENT_HALF_BIT];

  // channel 1 analog front end; codes 2 and 3 are flagged, not corrected
  assign first_channel_input_type =
    reg_ch1[cptc_pkg::CH1_INSRC_HI_BIT:cptc_pkg::CH1_INSRC_LO_BIT];
  assign first_channel_input_invalid = reg_ch1[cptc_pkg::CH1_INSRC_HI_BIT];
  assign first_channel_range_select     = reg_ch1[cptc_pkg::CH1_RANGE_BIT];
  assign first_channel_bandwidth_select = reg_ch1[cptc_pkg::CH1_BW_BIT];

  // a write to the adc tuning register shows on its controls one edge later
  property p_adc_write;
    @(posedge core_clk) disable iff (reset)
      (reg_wr_en && reg_addr == cptc_pkg::ADDR_ADC_POWER_TUNING) |=>
        (adc_modulator_half_rate == $past(reg_wdata[7]) && adc_comb_order_select == $past(reg_wdata[6])
         && adc_decim_filter_skip == $past(reg_wdata[5]) && adc_lowpower_filter_en == $past(reg_wdata[2]));
  endproperty
  AST_ADC_WRITE: assert property (p_adc_write) else $error("adc tuning controls wrong after write");

  AST_DAC_WRITE: assert property (@(posedge core_clk) disable iff (reset)
    (reg_wr_en && reg_addr == cptc_pkg::ADDR_DAC_POWER_TUNING) |=>
      (dac_modulator_half_rate == $past(reg_wdata[7]) && dac_interp_segmenter_skip == $past(reg_wdata[5])
       && dac_lowpower_filter_en == $past(reg_wdata[2]) && dac_ref_current_half == $past(reg_wdata[1])))
    else $error("dac tuning controls wrong after write");

  AST_CH1_WRITE: assert property (@(posedge core_clk) disable iff (reset)
    (reg_wr_en && reg_addr == cptc_pkg::ADDR_ADC_FIRST_CHANNEL) |=>
      (first_channel_input_type == $past(reg_wdata[7:6]) && first_channel_range_select == $past(reg_wdata[1])
       && first_channel_bandwidth_select == $past(reg_wdata[0])))
    else $error("channel 1 controls wrong after write");

  AST_HOLD: assert property (@(posedge core_clk) disable iff (reset)
    !reg_wr_en |=> $stable(adc_decim_filter_skip) && $stable(dac_interp_segmenter_skip))
    else $error("control changed without a write");

  sequence s_read_req;
    reg_rd_en && !reg_wr_en && reg_addr == cptc_pkg::ADDR_ADC_POWER_TUNING;
  endsequence
  sequence s_read_resp;
    reg_rvalid && (reg_rdata & ~cptc_pkg::MASK_ADC_POWER_TUNING) == 8'h00
      && reg_rdata[7] == adc_modulator_half_rate && reg_rdata[2] == adc_lowpower_filter_en;
  endsequence
  AST_RESERVED_ZERO: assert property (@(posedge core_clk) disable iff (reset)
    s_read_req |=> s_read_resp)
    else $error("reserved bits read nonzero or readback mismatch");

  AST_DAC_RES: assert property (@(posedge core_clk) disable iff (reset)
    (reg_rd_en && !reg_wr_en && reg_addr == cptc_pkg::ADDR_DAC_POWER_TUNING) |=>
      (reg_rdata & ~cptc_pkg::MASK_DAC_POWER_TUNING) == 8'h00 && reg_rdata[1] == dac_ref_current_half)
    else $error("dac register readback wrong");

  AST_RESET_ZERO: assert property (@(posedge core_clk)
    $fell(reset) |-> (!adc_comb_order_select && !dac_modulator_half_rate && first_channel_input_type == 2'h0
      && !first_channel_bandwidth_select && !reg_rvalid))
    else $error("controls not zero after reset");

  AST_INVALID: assert property (@(posedge core_clk) disable iff (reset)
    first_channel_input_invalid == (first_channel_input_type > cptc_pkg::INSRC_SINGLE_ENDED))
    else $error("input type invalid flag wrong");

  AST_CH1_BW: assert property (@(posedge core_clk) disable iff (reset)
    (reg_wr_en && reg_addr == cptc_pkg::ADDR_ADC_FIRST_CHANNEL && reg_wdata[0]) |=> ##[0:2] first_channel_bandwidth_select)
    else $error("bandwidth select missed");

  // per-field write checks; a bit landing in the wrong position shows up under its own label
  sequence s_adc_wr;
    reg_wr_en && reg_addr == cptc_pkg::ADDR_ADC_POWER_TUNING;
  endsequence

  sequence s_dac_wr;
    reg_wr_en && reg_addr == cptc_pkg::ADDR_DAC_POWER_TUNING;
  endsequence

  sequence s_ch1_wr;
    reg_wr_en && reg_addr == cptc_pkg::ADDR_ADC_FIRST_CHANNEL;
  endsequence

  AST_ADC_RATE: assert property (@(posedge core_clk) disable iff (reset)
    s_adc_wr |=> adc_modulator_half_rate == $past(reg_wdata[cptc_pkg::ADC_HALF_RATE_BIT]))
    else $error("adc modulator rate select wrong after write");

  AST_ADC_ORDER: assert property (@(posedge core_clk) disable iff (reset)
    s_adc_wr |=> adc_comb_order_select == $past(reg_wdata[cptc_pkg::ADC_COMB_ORDER_BIT]))
    else $error("adc comb order select wrong after write");

  AST_ADC_SKIP: assert property (@(posedge core_clk) disable iff (reset)
    s_adc_wr |=> adc_decim_filter_skip == $past(reg_wdata[cptc_pkg::ADC_FIR_SKIP_BIT]))
    else $error("adc filter skip wrong after write");

  AST_ADC_LOWPWR: assert property (@(posedge core_clk) disable iff (reset)
    s_adc_wr |=> adc_lowpower_filter_en == $past(reg_wdata[cptc_pkg::ADC_LOWPWR_BIT]))
    else $error("adc low power filter enable wrong after write");

  AST_DAC_RATE: assert property (@(posedge core_clk) disable iff (reset)
    s_dac_wr |=> dac_modulator_half_rate == $past(reg_wdata[cptc_pkg::DAC_HALF_RATE_BIT]))
    else $error("dac modulator rate select wrong after write");

  AST_DAC_SKIP: assert property (@(posedge core_clk) disable iff (reset)
    s_dac_wr |=> dac_interp_segmenter_skip == $past(reg_wdata[cptc_pkg::DAC_SEG_SKIP_BIT]))
    else $error("dac interpolator skip wrong after write");

  AST_DAC_LOWPWR: assert property (@(posedge core_clk) disable iff (reset)
    s_dac_wr |=> dac_lowpower_filter_en == $past(reg_wdata[cptc_pkg::DAC_LOWPWR_BIT]))
    else $error("dac low power filter enable wrong after write");

  AST_DAC_REFERENCE_CURRENT: assert property (@(posedge core_clk) disable iff (reset)
    s_dac_wr |=> dac_ref_current_half == $past(reg_wdata[cptc_pkg::DAC_REFERENCE_CURRENT_HALF_BIT]))
    else $error("dac reference current select wrong after write");

  AST_CH1_TYPE: assert property (@(posedge core_clk) disable iff (reset)
    s_ch1_wr |=> first_channel_input_type == $past(reg_wdata[cptc_pkg::CH1_INSRC_HI_BIT:cptc_pkg::CH1_INSRC_LO_BIT]))
    else $error("channel 1 input type wrong after write");

  AST_CH1_RANGE: assert property (@(posedge core_clk) disable iff (reset)
    s_ch1_wr |=> first_channel_range_select == $past(reg_wdata[cptc_pkg::CH1_RANGE_BIT]))
    else $error("channel 1 range select wrong after write");

  AST_CH1_BAND: assert property (@(posedge core_clk) disable iff (reset)
    s_ch1_wr |=> first_channel_bandwidth_select == $past(reg_wdata[cptc_pkg::CH1_BW_BIT]))
    else $error("channel 1 bandwidth select wrong after write");

  // controls must not drift while their register is left alone; a datapath would retune mid-stream
  AST_ADC_HOLD: assert property (@(posedge core_clk) disable iff (reset)
    !(reg_wr_en && reg_addr == cptc_pkg::ADDR_ADC_POWER_TUNING) |=>
      $stable(adc_modulator_half_rate) && $stable(adc_comb_order_select) && $stable(adc_lowpower_filter_en))
    else $error("adc controls changed without a write");

  AST_DAC_HOLD: assert property (@(posedge core_clk) disable iff (reset)
    !(reg_wr_en && reg_addr == cptc_pkg::ADDR_DAC_POWER_TUNING) |=>
      $stable(dac_modulator_half_rate) && $stable(dac_lowpower_filter_en) && $stable(dac_ref_current_half))
    else $error("dac controls changed without a write");

  AST_CH1_HOLD: assert property (@(posedge core_clk) disable iff (reset)
    !(reg_wr_en && reg_addr == cptc_pkg::ADDR_ADC_FIRST_CHANNEL) |=>
      $stable(first_channel_input_type) && $stable(first_channel_range_select)
      && $stable(first_channel_bandwidth_select))
    else $error("channel 1 controls changed without a write");

  // writes to holes in the map are dropped without any error signalled
  AST_UNMAPPED_WRITE: assert property (@(posedge core_clk) disable iff (reset)
    (reg_wr_en && reg_addr != cptc_pkg::ADDR_ADC_POWER_TUNING && reg_addr != cptc_pkg::ADDR_DAC_POWER_TUNING
     && reg_addr != cptc_pkg::ADDR_ADC_FIRST_CHANNEL) |=>
      $stable(adc_decim_filter_skip) && $stable(dac_interp_segmenter_skip) && $stable(first_channel_input_type))
    else $error("unmapped write changed a control");

  // read valid is a one-cycle echo of the read strobe
  AST_RVALID_SET: assert property (@(posedge core_clk) disable iff (reset)
    reg_rd_en |=> reg_rvalid)
    else $error("read valid missing after read strobe");

  AST_RVALID_CLR: assert property (@(posedge core_clk) disable iff (reset)
    !reg_rd_en |=> !reg_rvalid)
    else $error("read valid without read strobe");

  // readback of each register shows the same bits that drive the controls
  AST_ADC_READBACK: assert property (@(posedge core_clk) disable iff (reset)
    s_read_req |=> reg_rdata[cptc_pkg::ADC_COMB_ORDER_BIT] == adc_comb_order_select
      && reg_rdata[cptc_pkg::ADC_FIR_SKIP_BIT] == adc_decim_filter_skip)
    else $error("adc register readback wrong");

  AST_DAC_READBACK: assert property (@(posedge core_clk) disable iff (reset)
    (reg_rd_en && !reg_wr_en && reg_addr == cptc_pkg::ADDR_DAC_POWER_TUNING) |=>
      reg_rdata[cptc_pkg::DAC_HALF_RATE_BIT] == dac_modulator_half_rate
      && reg_rdata[cptc_pkg::DAC_SEG_SKIP_BIT] == dac_interp_segmenter_skip
      && reg_rdata[cptc_pkg::DAC_LOWPWR_BIT] == dac_lowpower_filter_en)
    else $error("dac register readback wrong");

  AST_CH1_RES: assert property (@(posedge core_clk) disable iff (reset)
    (reg_rd_en && !reg_wr_en && reg_addr == cptc_pkg::ADDR_ADC_FIRST_CHANNEL) |=>
      (reg_rdata & ~cptc_pkg::MASK_ADC_FIRST_CHANNEL) == 8'h00
      && reg_rdata[cptc_pkg::CH1_RANGE_BIT] == first_channel_range_select
      && reg_rdata[cptc_pkg::CH1_BW_BIT] == first_channel_bandwidth_select)
    else $error("channel 1 register readback wrong");

  AST_UNMAPPED_READ: assert property (@(posedge core_clk) disable iff (reset)
    (reg_rd_en && reg_addr != cptc_pkg::ADDR_ADC_POWER_TUNING && reg_addr != cptc_pkg::ADDR_DAC_POWER_TUNING
     && reg_addr != cptc_pkg::ADDR_ADC_FIRST_CHANNEL) |=> reg_rdata == cptc_pkg::READ_UNMAPPED)
    else $error("unmapped read returned nonzero");

  // the remaining controls and the read data also start from zero
  AST_RESET_REST: assert property (@(posedge core_clk)
    $fell(reset) |-> (!adc_modulator_half_rate && !adc_decim_filter_skip && !adc_lowpower_filter_en
      && !dac_interp_segmenter_skip && !dac_lowpower_filter_en && !dac_ref_current_half
      && !first_channel_range_select && !first_channel_input_invalid && reg_rdata == cptc_pkg::REG_RESET))
    else $error("remaining controls not zero after reset");

endmodule
`default_nettype wire

// ==== codec_power_tune_and_adc_ch1_config_tb_top.sv ====
// testbench: register access, field mapping and reset checks for the power tune bank
`timescale 1ns/1ps
`default_nettype none
module codec_power_tune_and_adc_ch1_config_tb_top;
  localparam logic [7:0] ADDRS [3] = '{cptc_pkg::ADDR_ADC_POWER_TUNING, cptc_pkg::ADDR_DAC_POWER_TUNING,
                                       cptc_pkg::ADDR_ADC_FIRST_CHANNEL};
  localparam logic [7:0] MASKS [3] = '{cptc_pkg::MASK_ADC_POWER_TUNING, cptc_pkg::MASK_DAC_POWER_TUNING,
                                       cptc_pkg::MASK_ADC_FIRST_CHANNEL};
  logic        core_clk  = 1'b0;
  logic        reset     = 1'b1;
  logic        reg_wr_en = 1'b0;
  logic        reg_rd_en = 1'b0;
  logic [7:0]  reg_addr  = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  reg_rdata;
  logic        reg_rvalid;
  wire  logic [12:0] ctl;
  logic [7:0]  exp_reg [3] = '{8'h00, 8'h00, 8'h00};
  int          miscompares = 0;
  int          check_count = 0;

  // 200 MHz core clock
  always #2.5 core_clk = ~core_clk;

  cptc_bank cptc_bank_i (
    .core_clk                       (core_clk),
    .reset                          (reset),
    .reg_wr_en                      (reg_wr_en),
    .reg_rd_en                      (reg_rd_en),
    .reg_addr                       (reg_addr),
    .reg_wdata                      (reg_wdata),
    .reg_rdata                      (reg_rdata),
    .reg_rvalid                     (reg_rvalid),
    .adc_modulator_half_rate        (ctl[12]),
    .adc_comb_order_select          (ctl[11]),
    .adc_decim_filter_skip          (ctl[10]),
    .adc_lowpower_filter_en         (ctl[9]),
    .dac_modulator_half_rate        (ctl[8]),
    .dac_interp_segmenter_skip      (ctl[7]),
    .dac_lowpower_filter_en         (ctl[6]),
    .dac_ref_current_half           (ctl[5]),
    .first_channel_input_type       (ctl[4:3]),
    .first_channel_range_select     (ctl[2]),
    .first_channel_bandwidth_select (ctl[1]),
    .first_channel_input_invalid    (ctl[0])
  );

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // control pins are compared as one vector so every field is checked at once
  task automatic cmp_ctl();
    logic [12:0] e;
    e = {exp_reg[0][7:5], exp_reg[0][2], exp_reg[1][7], exp_reg[1][5], exp_reg[1][2:1],
         exp_reg[2][7:6], exp_reg[2][1:0], (exp_reg[2][7:6] > cptc_pkg::INSRC_SINGLE_ENDED)};
    check_count++;
    if (ctl !== e) begin
      miscompares++;
      $display("mismatch at %0t: controls got %h expected %h", $time, ctl, e);
    end
  endtask

  // one-cycle write strobe; the model keeps only the writable bits
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr_en <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr_en <= 1'b0;
    for (int i = 0; i < 3; i++) if (a == ADDRS[i]) exp_reg[i] = d & MASKS[i];
    #1;
  endtask

  // read strobe, optionally with a write in the same cycle; waits a bounded time for the answer
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic also_wr = 1'b0);
    int n;
    @(posedge core_clk);
    reg_rd_en <= 1'b1;
    reg_wr_en <= also_wr;
    reg_addr  <= a;
    reg_wdata <= 8'hFF;
    @(posedge core_clk);
    reg_rd_en <= 1'b0;
    reg_wr_en <= 1'b0;
    for (n = 0; n < 4; n++) begin
      #1;
      if (reg_rvalid === 1'b1) break;
      @(posedge core_clk);
    end
    if (n == 4) begin
      miscompares++;
      $display("mismatch at %0t: read answer never came", $time);
      final_report();
    end else begin
      cmp8(8'(n), 8'h00, "read latency");
      cmp8(reg_rdata, exp, "read data");
    end
  endtask

  task automatic t_reset_values();
    for (int i = 0; i < 3; i++) rd(ADDRS[i], 8'h00);
    cmp_ctl();
  endtask

  // single set bits through every position of every register, then all ones
  task automatic t_walk_bits();
    for (int r = 0; r < 3; r++) begin
      for (int b = 0; b < 8; b++) begin
        wr(ADDRS[r], 8'h01 << b);
        cmp_ctl();
        rd(ADDRS[r], exp_reg[r]);
      end
      wr(ADDRS[r], 8'hFF);
      rd(ADDRS[r], MASKS[r]);
    end
    cmp_ctl();
  endtask

  // every input type code, including the two that are flagged
  task automatic t_input_codes();
    for (int c = 0; c < 4; c++) begin
      wr(cptc_pkg::ADDR_ADC_FIRST_CHANNEL, {c[1:0], 6'h01});
      cmp_ctl();
    end
  endtask

  // writes to unmapped places change nothing and read zero
  task automatic t_unmapped();
    logic [7:0] a [4] = '{8'h4D, 8'h51, 8'h00, 8'hFF};
    for (int i = 0; i < 4; i++) begin
      wr(a[i], 8'h00);
      cmp_ctl();
      rd(a[i], 8'h00);
    end
  endtask

  // read and write together return the old value, the next read the new one
  task automatic t_same_cycle();
    wr(cptc_pkg::ADDR_DAC_POWER_TUNING, 8'h00);
    rd(cptc_pkg::ADDR_DAC_POWER_TUNING, 8'h00, 1'b1);
    exp_reg[1] = MASKS[1];
    cmp_ctl();
    rd(cptc_pkg::ADDR_DAC_POWER_TUNING, MASKS[1]);
  endtask

  // a reset in mid-run clears every register again
  task automatic t_mid_reset();
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    exp_reg = '{8'h00, 8'h00, 8'h00};
    #1;
    cmp_ctl();
    t_reset_values();
  endtask

  initial begin
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    t_reset_values();
    t_walk_bits(); // no converter stream runs while settings change
    t_input_codes();
    t_unmapped();
    t_same_cycle();
    t_mid_reset();
    final_report();
  end
endmodule
`default_nettype wire
